// *** logic/sbc_core.sv ***
`include "sbc_cfg.svh"

module sbc_core #(
  parameter logic [15:0] CRC_POLY = `SBC_CRC_POLY,
  parameter logic [15:0] CRC_SEED = `SBC_CRC_SEED
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic RX_VALID,
  input wire logic [7:0] RX_DATA,
  output logic RX_READY,
  output logic TX_VALID,
  output logic [7:0] TX_DATA,
  input wire logic TX_READY,
  input wire logic TX_DONE,
  input wire logic FLASH_BLANK,
  input wire logic [7:0] ID_STORED [0:`SBC_ID_SLOTS-1],
  input wire logic CRC_INIT,
  output logic [2:0] BAUD_SEL,
  output logic ID_OK,
  output logic PG_DATA_VALID,
  output logic [7:0] PG_DATA
);

  // ****************************************
  // CRC step function
  // ****************************************

  // One byte of MSB-first CRC, shared by the page data path.
  function automatic logic [15:0] sbc_crc8(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      if (r[15] ^ d[i]) begin
        r = {r[14:0], 1'b0} ^ CRC_POLY;
      end else begin
        r = {r[14:0], 1'b0};
      end
    end
    return r;
  endfunction

  // Baud opcode range check, used by the opcode decode in SBC_IDLE.
  function automatic logic sbc_is_baud(input logic [7:0] op);
    return (op >= `SBC_OP_BAUD_9600) && (op <= `SBC_OP_BAUD_115200);
  endfunction

  // ****************************************
  // Two-entry transmit buffer
  // ****************************************

  logic [7:0] buf_mem [0:1];
  logic buf_wp_reg;
  logic buf_rp_reg;
  logic [1:0] buf_cnt_reg;
  logic buf_push;
  logic buf_pop;
  logic [7:0] buf_din;
  wire buf_full = (buf_cnt_reg == 2'h2);
  wire buf_empty = (buf_cnt_reg == 2'h0);

  // A receiver stall fills the buffer, and a full buffer stalls the interpreter.
  assign buf_pop = TX_VALID && TX_READY;

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      buf_wp_reg <= 1'b0;
      buf_rp_reg <= 1'b0;
      buf_cnt_reg <= 2'h0;
    end else begin
      buf_wp_reg <= buf_wp_reg ^ buf_push;
      buf_rp_reg <= buf_rp_reg ^ buf_pop;
      buf_cnt_reg <= buf_cnt_reg + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end

  // Storage needs no reset; the count guards every read.
  always_ff @(posedge CLOCK) begin
    if (buf_push) begin
      buf_mem[buf_wp_reg] <= buf_din;
    end
  end

  // Output stage registered so the port comes from a flip-flop.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      TX_VALID <= 1'b0;
      TX_DATA <= 8'h00;
    end else if (!TX_VALID || TX_READY) begin
      TX_VALID <= 1'b0;
      if (!buf_empty && !(TX_VALID && TX_READY && buf_cnt_reg == 2'h1)) begin
        TX_VALID <= 1'b1;
        TX_DATA <= buf_mem[buf_rp_reg ^ buf_pop];
      end
    end
  end

  // ****************************************
  // Interpreter state
  // ****************************************

  sbc_pkg::sbc_state_t state_reg, state_next;
  logic [2:0] cnt_reg, cnt_next;
  logic [8:0] pg_cnt_reg, pg_cnt_next;
  logic [7:0] id_len_reg, id_len_next;
  logic [7:0] id_idx_reg, id_idx_next;
  logic [7:0] op_reg, op_next;
  logic id_ok_reg, id_ok_next;
  logic id_bad_reg, id_bad_next;
  logic [15:0] crc_reg;
  logic [2:0] baud_reg, baud_next;

  wire rx_take = RX_VALID && RX_READY;
  // RULE_16 blank array opens
  wire unlocked = FLASH_BLANK || id_ok_reg;
  wire rx_can = (state_reg == sbc_pkg::SBC_IDLE) || (state_reg == sbc_pkg::SBC_ID_ADDR)
    || (state_reg == sbc_pkg::SBC_ID_CNT) || (state_reg == sbc_pkg::SBC_ID_DATA)
    || (state_reg == sbc_pkg::SBC_PG_ADDR) || (state_reg == sbc_pkg::SBC_PG_DATA);
  // RULE_06 byte-wise compare
  wire [7:0] id_ref = (id_idx_reg < `SBC_ID_SLOTS) ? ID_STORED[id_idx_reg[2:0]] : 8'h00;
  wire id_miss = (id_idx_reg >= `SBC_ID_SLOTS) || (RX_DATA != id_ref);

  // Decode of the next state from the byte stream.
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    pg_cnt_next = pg_cnt_reg;
    id_len_next = id_len_reg;
    id_idx_next = id_idx_reg;
    op_next = op_reg;
    id_ok_next = id_ok_reg;
    id_bad_next = id_bad_reg;
    baud_next = baud_reg;
    buf_push = 1'b0;
    buf_din = 8'h00;
    case (state_reg)
      sbc_pkg::SBC_IDLE: begin
        if (rx_take) begin
          op_next = RX_DATA;
          cnt_next = 3'h0;
          // RULE_01 opcode first
          if (RX_DATA == `SBC_OP_ID_CHECK) begin
            state_next = sbc_pkg::SBC_ID_ADDR;
          // RULE_19 silent discard
          end else if (!unlocked) begin
            state_next = sbc_pkg::SBC_IDLE;
          end else if (RX_DATA == `SBC_OP_PAGE_PROG) begin
            state_next = sbc_pkg::SBC_PG_ADDR;
          end else if (RX_DATA == `SBC_OP_READ_CHECK) begin
            state_next = sbc_pkg::SBC_TX_LOW;
          end else if (sbc_is_baud(RX_DATA)) begin
            state_next = sbc_pkg::SBC_BAUD_ECHO;
          end
        end
      end
      sbc_pkg::SBC_ID_ADDR: begin
        // RULE_02 three address bytes
        if (rx_take) begin
          cnt_next = cnt_reg + 3'h1;
          if (cnt_reg == 3'h2) begin
            state_next = sbc_pkg::SBC_ID_CNT;
          end
        end
      end
      sbc_pkg::SBC_ID_CNT: begin
        // RULE_03 count byte
        if (rx_take) begin
          id_len_next = RX_DATA;
          id_idx_next = 8'h00;
          id_bad_next = 1'b0;
          if (RX_DATA == 8'h00) begin
            id_ok_next = 1'b1;
            state_next = sbc_pkg::SBC_IDLE;
          end else begin
            state_next = sbc_pkg::SBC_ID_DATA;
          end
        end
      end
      sbc_pkg::SBC_ID_DATA: begin
        // RULE_04 ascending code bytes
        if (rx_take) begin
          id_idx_next = id_idx_reg + 8'h01;
          if (id_idx_reg + 8'h01 == id_len_reg) begin
            // RULE_05 mismatch locks
            id_ok_next = !(id_bad_reg || id_miss);
            state_next = sbc_pkg::SBC_IDLE;
          end else begin
            id_bad_next = id_bad_reg || id_miss;
          end
        end
      end
      sbc_pkg::SBC_PG_ADDR: begin
        // RULE_17 two address bytes
        if (rx_take) begin
          cnt_next = cnt_reg + 3'h1;
          pg_cnt_next = 9'h000;
          if (cnt_reg == 3'h1) begin
            state_next = sbc_pkg::SBC_PG_DATA;
          end
        end
      end
      sbc_pkg::SBC_PG_DATA: begin
        if (rx_take) begin
          pg_cnt_next = pg_cnt_reg + 9'h001;
          if (pg_cnt_reg + 9'h001 == `SBC_PAGE_BYTES) begin
            state_next = sbc_pkg::SBC_IDLE;
          end
        end
      end
      sbc_pkg::SBC_TX_LOW: begin
        // RULE_07 low byte first
        if (!buf_full) begin
          buf_push = 1'b1;
          buf_din = crc_reg[7:0];
          state_next = sbc_pkg::SBC_TX_HIGH;
        end
      end
      sbc_pkg::SBC_TX_HIGH: begin
        if (!buf_full) begin
          buf_push = 1'b1;
          buf_din = crc_reg[15:8];
          state_next = sbc_pkg::SBC_IDLE;
        end
      end
      sbc_pkg::SBC_BAUD_ECHO: begin
        // RULE_10 echo before switch
        if (!buf_full) begin
          buf_push = 1'b1;
          buf_din = op_reg;
          state_next = sbc_pkg::SBC_BAUD_WAIT;
        end
      end
      sbc_pkg::SBC_BAUD_WAIT: begin
        // RULE_11 RULE_12 RULE_13 RULE_14 RULE_15 speed from opcode
        if (buf_empty && !TX_VALID && TX_DONE) begin
          baud_next = 3'(op_reg - `SBC_OP_BAUD_9600);
          state_next = sbc_pkg::SBC_IDLE;
        end
      end
      default: begin
        state_next = sbc_pkg::SBC_IDLE;
      end
    endcase
  end

  // State registers.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= sbc_pkg::SBC_IDLE;
      cnt_reg <= 3'h0;
      pg_cnt_reg <= 9'h000;
      id_len_reg <= 8'h00;
      id_idx_reg <= 8'h00;
      op_reg <= 8'h00;
      id_ok_reg <= 1'b0;
      id_bad_reg <= 1'b0;
      baud_reg <= `SBC_BAUD_RESET;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      pg_cnt_reg <= pg_cnt_next;
      id_len_reg <= id_len_next;
      id_idx_reg <= id_idx_next;
      op_reg <= op_next;
      id_ok_reg <= id_ok_next;
      id_bad_reg <= id_bad_next;
      baud_reg <= baud_next;
    end
  end

  // RULE_08 RULE_18 CRC over page data
  // Initialise wins over a data byte; the programmer never overlaps them.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      crc_reg <= CRC_SEED;
    end else if (CRC_INIT) begin
      crc_reg <= CRC_SEED;
    end else if (rx_take && state_reg == sbc_pkg::SBC_PG_DATA) begin
      crc_reg <= sbc_crc8(crc_reg, RX_DATA);
    end
  end

  // Registered outputs.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      RX_READY <= 1'b0;
      BAUD_SEL <= `SBC_BAUD_RESET;
      ID_OK <= 1'b0;
      PG_DATA_VALID <= 1'b0;
      PG_DATA <= 8'h00;
    end else begin
      RX_READY <= rx_can && (state_next == state_reg || state_next == sbc_pkg::SBC_IDLE
        || state_next == sbc_pkg::SBC_ID_ADDR || state_next == sbc_pkg::SBC_ID_CNT
        || state_next == sbc_pkg::SBC_ID_DATA || state_next == sbc_pkg::SBC_PG_ADDR
        || state_next == sbc_pkg::SBC_PG_DATA);
      BAUD_SEL <= baud_next;
      ID_OK <= id_ok_next;
      PG_DATA_VALID <= rx_take && state_reg == sbc_pkg::SBC_PG_DATA;
      PG_DATA <= RX_DATA;
    end
  end

endmodule // sbc_core

// *** logic/sbc_cfg.svh ***
`ifndef SBC_CFG_SVH
`define SBC_CFG_SVH
// What this block does
// RULE_01: Programmer sends the identification-check opcode as the first command byte.
// RULE_02: Bytes two to four carry the low, middle, high address of the first code byte.
// RULE_03: Fifth byte gives how many identification bytes follow; used as count.
// RULE_04: Identification bytes follow from the sixth byte in ascending order.
// RULE_05: On a non-blank array, any mismatching byte locks out later commands.
// RULE_06: Each identification element is one stored byte, compared byte by byte.
// RULE_07: Read check data returns the 16-bit value, low byte then high byte.
// RULE_08: Check value is a CRC over all page program data since initialisation.
// RULE_09: Programmer reads once, initialises, programs pages, then reads again.
// RULE_10: Baud commands echo their opcode first, and only then change speed.
// RULE_11: First baud opcode selects 9600 bits per second after the echo.
// RULE_12: Second baud opcode selects 19200 bits per second after the echo.
// RULE_13: Third baud opcode selects 38400 bits per second after the echo.
// RULE_14: Fourth baud opcode selects 57600 bits per second after the echo.
// RULE_15: Fifth baud opcode selects 115200 bits per second after the echo.
// RULE_16: A totally blank array accepts every command without an identification match.
// RULE_17: Page program is opcode, two address bytes, 256 data bytes feeding the CRC.
// RULE_18: CRC polynomial and seed are parameters, default CCITT with all-ones seed.
// RULE_19: Until matched on a non-blank array, other opcodes are dropped silently.

// ****************************************
// Opcodes
// ****************************************
`define SBC_OP_ID_CHECK 8'hF5
`define SBC_OP_READ_CHECK 8'hFD
`define SBC_OP_PAGE_PROG 8'h41
`define SBC_OP_BAUD_9600 8'hB0
`define SBC_OP_BAUD_19200 8'hB1
`define SBC_OP_BAUD_38400 8'hB2
`define SBC_OP_BAUD_57600 8'hB3
`define SBC_OP_BAUD_115200 8'hB4

// ****************************************
// Counts and reset values
// ****************************************
`define SBC_PAGE_BYTES 9'h100
`define SBC_ID_SLOTS 7
`define SBC_CRC_POLY 16'h1021
`define SBC_CRC_SEED 16'hFFFF
`define SBC_BAUD_RESET 3'h0
`endif

// *** logic/sbc_pkg.sv ***
package sbc_pkg;
  // Link speed selection as driven to the serial port.
  typedef enum logic [2:0] {
    SBC_BAUD_9600 = 3'h0,
    SBC_BAUD_19200 = 3'h1,
    SBC_BAUD_38400 = 3'h2,
    SBC_BAUD_57600 = 3'h3,
    SBC_BAUD_115200 = 3'h4
  } sbc_baud_t;

  // Interpreter states, Gray coded in declaration order.
  typedef enum logic [3:0] {
    SBC_IDLE = 4'h0,
    SBC_ID_ADDR = 4'h1,
    SBC_ID_CNT = 4'h3,
    SBC_ID_DATA = 4'h2,
    SBC_PG_ADDR = 4'h6,
    SBC_PG_DATA = 4'h7,
    SBC_TX_LOW = 4'h5,
    SBC_TX_HIGH = 4'h4,
    SBC_BAUD_ECHO = 4'hC,
    SBC_BAUD_WAIT = 4'hD
  } sbc_state_t;
endpackage : sbc_pkg

// *** bench/sbc_link_model.sv ***
// ****************************************
// Serial link transmitter stand-in
// ****************************************
module sbc_link_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output logic tx_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got [$];
  int busy_cnt;
  // Each accepted byte keeps the line busy; slow mode stands for a low baud rate.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt <= 1;
    end else if (tx_valid && tx_ready) begin
      got.push_back(tx_data);
      busy_cnt <= slow ? 20 : 2;
    end else if (busy_cnt > 0) begin
      busy_cnt <= busy_cnt - 1;
    end
  end
  // The line is idle exactly when a new byte would be accepted.
  assign tx_ready = rst_n && busy_cnt == 0;
  assign tx_done = tx_ready;
endmodule // sbc_link_model

// *** bench/sbc_core_asserts.sv ***
module sbc_core_asserts (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic RX_VALID,
  input wire logic [7:0] RX_DATA,
  input wire logic RX_READY,
  input wire logic TX_VALID,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_READY,
  input wire logic TX_DONE,
  input wire logic FLASH_BLANK,
  input wire logic [2:0] BAUD_SEL,
  input wire logic ID_OK,
  input wire logic PG_DATA_VALID,
  input wire logic [7:0] PG_DATA
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  logic [7:0] op_reg;
  wire take = RX_VALID && RX_READY;
  wire open_ok = FLASH_BLANK || ID_OK;
  // Last byte taken; after an accepted read or baud opcode no byte is taken until its reply has been queued for sending.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      op_reg <= 8'h00;
    end else if (take) begin
      op_reg <= RX_DATA;
    end
  end
  sequence s_read_cmd;
    take && RX_DATA == 8'hFD && open_ok;
  endsequence
  sequence s_baud_cmd;
    take && RX_DATA inside {[8'hB0:8'hB4]} && open_ok;
  endsequence
  a_tx_hold: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
    else $error("tx byte changed before acceptance");
  a_read_reply: assert property (s_read_cmd |-> ##[1:4] TX_VALID)
    else $error("no check data reply");
  a_read_busy: assert property (s_read_cmd |-> ##2 !RX_READY)
    else $error("receiver open during reply");
  a_echo_code: assert property (s_baud_cmd |-> ##[1:4] (TX_VALID && TX_DATA == op_reg))
    else $error("baud echo missing or wrong");
  a_baud_late: assert property ($changed(BAUD_SEL) |-> $past(!TX_VALID && TX_DONE))
    else $error("speed changed before echo left");
  a_baud_code: assert property ($changed(BAUD_SEL) |-> op_reg == {5'h16, BAUD_SEL})
    else $error("speed does not match opcode");
  a_tx_locked: assert property (TX_VALID |-> open_ok)
    else $error("reply while locked");
  a_pg_follow: assert property (PG_DATA_VALID |-> $past(take) && PG_DATA == $past(RX_DATA))
    else $error("page byte not the one taken");
  a_id_settle: assert property ($changed(ID_OK) |-> $past(take))
    else $error("match result moved without a byte");
endmodule // sbc_core_asserts

bind sbc_core sbc_core_asserts chk (.CLOCK(CLOCK), .RST_N(RST_N), .RX_VALID(RX_VALID),
  .RX_DATA(RX_DATA), .RX_READY(RX_READY), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA),
  .TX_READY(TX_READY), .TX_DONE(TX_DONE), .FLASH_BLANK(FLASH_BLANK), .BAUD_SEL(BAUD_SEL),
  .ID_OK(ID_OK), .PG_DATA_VALID(PG_DATA_VALID), .PG_DATA(PG_DATA));

// *** bench/tb.sv ***
`include "sbc_cfg.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic rx_valid = 1'b0;
  logic [7:0] rx_data = 8'h00;
  logic crc_init = 1'b0;
  logic blank = 1'b1;
  logic slow = 1'b0;
  logic [7:0] id_mem [0:`SBC_ID_SLOTS-1];
  logic rx_ready, tx_valid, tx_ready, tx_done, id_ok, pg_valid;
  logic [7:0] tx_data, pg_data, b;
  logic [2:0] baud_sel;
  logic [15:0] exp;
  int n0;
  int error_cnt = 0;
  int compares = 0;
  logic [15:0] pg_crc = `SBC_CRC_SEED;
  int pg_seen = 0;
  sbc_core uut (.CLOCK(clock), .RST_N(rst_n), .RX_VALID(rx_valid), .RX_DATA(rx_data),
    .RX_READY(rx_ready), .TX_VALID(tx_valid), .TX_DATA(tx_data), .TX_READY(tx_ready),
    .TX_DONE(tx_done), .FLASH_BLANK(blank), .ID_STORED(id_mem), .CRC_INIT(crc_init),
    .BAUD_SEL(baud_sel), .ID_OK(id_ok), .PG_DATA_VALID(pg_valid), .PG_DATA(pg_data));
  sbc_link_model lnk (.clk(clock), .rst_n(rst_n), .slow(slow), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .tx_done(tx_done));
  always #5 clock = ~clock;
  // Folds the forwarded page stream into its own CRC, so order and count are both checked.
  always @(negedge clock) begin
    if (pg_valid === 1'b1) begin
      pg_crc = crc_byte(pg_crc, pg_data);
      pg_seen++;
    end
  end
  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  // Called at a falling edge; the byte stands until the receiver is seen ready.
  task automatic send(input logic [7:0] v);
    int n;
    n = 0;
    rx_valid = 1'b1;
    rx_data = v;
    while (rx_ready !== 1'b1 && n < 200) begin
      @(negedge clock);
      n++;
    end
    @(negedge clock);
  endtask
  task automatic idle(input int k);
    rx_valid = 1'b0;
    repeat (k) @(negedge clock);
  endtask
  // Bitwise CRC, most significant bit first, no final inversion.
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    c ^= {d, 8'h00};
    for (int i = 0; i < 8; i++) c = c[15] ? (c << 1) ^ `SBC_CRC_POLY : c << 1;
    return c;
  endfunction
  task automatic read_check(input logic [15:0] e, input logic locked);
    int m;
    m = lnk.got.size();
    send(`SBC_OP_READ_CHECK);
    idle(1);
    for (int i = 0; i < 60 && lnk.got.size() < m + 2; i++) @(negedge clock);
    if (locked) begin
      chk("reply count", 16'h0000, 16'(lnk.got.size() - m));
    end else begin
      chk("check low", {8'h00, e[7:0]}, {8'h00, lnk.got[m]});
      chk("check high", {8'h00, e[15:8]}, {8'h00, lnk.got[m+1]});
    end
  endtask
  task automatic id_check(input int n, input int bad);
    send(`SBC_OP_ID_CHECK);
    repeat (3) send(8'($urandom) & 8'h7F);
    send(8'(n));
    for (int i = 0; i < n; i++) send(id_mem[i] ^ {7'h00, i == bad});
    idle(3);
  endtask
  task automatic stop_test();
    if (error_cnt == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(84));
    foreach (id_mem[i]) id_mem[i] = 8'($urandom) & 8'h7F;
    repeat (10) @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    read_check(`SBC_CRC_SEED, 1'b0);
    crc_init = 1'b1;
    @(negedge clock);
    crc_init = 1'b0;
    exp = `SBC_CRC_SEED;
    send(`SBC_OP_PAGE_PROG);
    repeat (2) send(8'($urandom) & 8'h7F);
    // Data kept below 8'h80 so the checker never mistakes it for an opcode.
    for (int i = 0; i < 256; i++) begin
      b = 8'($urandom) & 8'h7F;
      exp = crc_byte(exp, b);
      send(b);
    end
    idle(2);
    chk("page count", 16'h0100, 16'(pg_seen));
    chk("page stream", exp, pg_crc);
    slow = 1'b1;
    read_check(exp, 1'b0);
    for (int i = 4; i >= 0; i--) begin
      slow = i[0];
      n0 = lnk.got.size();
      send(8'hB0 + 8'(i));
      idle(1);
      for (int k = 0; k < 80 && baud_sel !== 3'(i); k++) @(negedge clock);
      chk("echo", 16'hB0 + 16'(i), {8'h00, lnk.got[n0]});
      chk("baud", 16'(i), {13'h0000, baud_sel});
    end
    slow = 1'b0;
    blank = 1'b0;
    read_check(16'h0000, 1'b1);
    id_check(7, 4);
    chk("id wrong", 16'h0000, {15'h0000, id_ok});
    n0 = lnk.got.size();
    send(8'hB1);
    idle(30);
    chk("locked echo", 16'(n0), 16'(lnk.got.size()));
    id_check(7, 9);
    chk("id full", 16'h0001, {15'h0000, id_ok});
    id_check(3, 1);
    chk("id part bad", 16'h0000, {15'h0000, id_ok});
    id_check(3, 9);
    chk("id part", 16'h0001, {15'h0000, id_ok});
    read_check(exp, 1'b0);
    // Initialising after data must bring the check value back to its seed.
    crc_init = 1'b1;
    @(negedge clock);
    crc_init = 1'b0;
    read_check(`SBC_CRC_SEED, 1'b0);
    stop_test();
  end
  // Cuts a hang short well beyond the several hundred cycles the sequence needs.
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    stop_test();
  end
endmodule // tb
